// ---- src/sah_pkg.sv ----
`include "sah_regs.svh"

package sah_pkg;

   // ------------------------------------------------------------
   // Link protocol states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_GC_CMD,
      ST_DATA,
      ST_ACK,
      ST_IGNORE
   } sah_state_e;

   // ------------------------------------------------------------
   // State of the logic on the link clock
   // ------------------------------------------------------------
   typedef struct packed {
      sah_state_e st;
      sah_state_e after;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic oe;
      logic sda_lvl;
      logic scl_q;
      logic sda_q;
      logic gc;
      logic cbus;
      logic tog_rst;
      logic tog_load;
      logic tog_rx;
      logic [7:0] rx_byte;
      logic to_q;
      logic addr_q;
      logic [6:0] own;
   } sah_link_s;

   // ------------------------------------------------------------
   // State of the logic on the system clock
   // ------------------------------------------------------------
   typedef struct packed {
      logic boot;
      logic tog_rst_q;
      logic tog_load_q;
      logic tog_rx_q;
      logic tog_to;
      logic tog_addr;
      logic [6:0] prog_addr;
      logic soft_reset;
      logic [7:0] rx_data;
      logic rx_valid;
      logic timeout;
      logic cbus;
      logic [`SAH_TO_CNT_W-1:0] to_cnt;
   } sah_sys_s;

endpackage

// ---- src/sah_regs.svh ----
`ifndef SAH_REGS_SVH
`define SAH_REGS_SVH

// ------------------------------------------------------------
// Bus codes
// ------------------------------------------------------------
`define SAH_GC_ADDR 7'h00
`define SAH_CBUS_ADDR 7'h01
`define SAH_START_BYTE 8'h01
`define SAH_GC_RESET_LOAD 8'h06
`define SAH_GC_LOAD_ONLY 8'h04
`define SAH_BITS_PER_BYTE 4'h8

// ------------------------------------------------------------
// Timing and reset values
// ------------------------------------------------------------
`define SAH_CLK_SYS_HZ 50000000
`define SAH_TIMEOUT_MS 35
`define SAH_TIMEOUT_CYC (`SAH_TIMEOUT_MS * (`SAH_CLK_SYS_HZ / 1000))
`define SAH_TO_CNT_W 21
`define SAH_OWN_ADDR_RST 7'h50
`define SAH_PROG_W_RST 3

`endif

// ---- src/sah_special_addr.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "sah_regs.svh"

module sah_special_addr #(
   parameter int PROG_W = `SAH_PROG_W_RST,
   parameter logic [6:0] OWN_ADDR = `SAH_OWN_ADDR_RST,
   parameter int TIMEOUT_CYC = `SAH_TIMEOUT_CYC
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic clk_link, // Free-running link sampling clock
   input wire logic scl_i, // Bus clock pin level
   input wire logic sda_i, // Bus data pin level
   output logic sda_o, // Data pin drive level, always low
   output logic sda_oe, // High while pulling data low
   input wire logic third_line_data_enable, // CBUS third line, active high
   input wire logic gc_enable, // Acknowledge general call when high
   input wire logic smbus_mode, // Enable clock-low timeout
   input wire logic [PROG_W-1:0] addr_pins, // Programmable address straps
   output logic [PROG_W-1:0] prog_addr, // Latched programmable address
   output logic soft_reset, // One-cycle reset pulse from general call
   output logic [7:0] rx_data, // Byte written to own address
   output logic rx_valid, // One-cycle pulse with rx_data
   output logic timeout, // One-cycle pulse on clock-low timeout
   output logic cbus_busy // CBUS traffic in progress
);

   localparam logic [6:0] PMASK = 7'((1 << PROG_W) - 1);
   localparam logic [`SAH_TO_CNT_W-1:0] TO_LAST = `SAH_TO_CNT_W'(TIMEOUT_CYC - 1);
   localparam logic [`SAH_TO_CNT_W-1:0] TO_CAP = `SAH_TO_CNT_W'(TIMEOUT_CYC);
   localparam sah_pkg::sah_sys_s SYS_RST = '{boot: 1'b1, default: '0};
   // Reset sees both lines idle high, so no false edge follows its release.
   localparam sah_pkg::sah_link_s LINK_RST = '{st: sah_pkg::ST_IDLE, after: sah_pkg::ST_IDLE,
      scl_q: 1'b1, sda_q: 1'b1, default: '0};

   if (PROG_W < 1 || PROG_W > 7 || TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << `SAH_TO_CNT_W))
   begin : g_chk
      $error("sah_special_addr parameters out of range");
   end

   sah_pkg::sah_link_s link_ff;
   sah_pkg::sah_link_s nxt_link;
   sah_pkg::sah_sys_s sys_ff;
   sah_pkg::sah_sys_s nxt_sys;

   logic rst_link;
   logic scl_f;
   logic sda_f;
   logic third_line_data_enable_f;
   logic gc_en_l;
   logic to_s;
   logic addr_s;
   logic scl_s;
   logic [PROG_W-1:0] pins_f;
   logic [6:0] pins_w;
   logic [3:0] tog_s;

   // ------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------
   sah_sync #(.W(1), .FILTER(1'b0)) u_rst_link (
      .clk(clk_link),
      .rst(1'b0),
      .d(rst),
      .q(rst_link)
   );

   // Continuous fast sampling finds every START, so no slow poll phase exists.
   // The pin filters run through reset so they hold settled levels when it ends.
   sah_sync #(.W(4), .FILTER(1'b1)) u_pins_link (
      .clk(clk_link),
      .rst(1'b0),
      .d({scl_i, sda_i, third_line_data_enable, gc_enable}),
      .q({scl_f, sda_f, third_line_data_enable_f, gc_en_l})
   );

   sah_sync #(.W(2), .FILTER(1'b1)) u_to_link (
      .clk(clk_link),
      .rst(rst_link),
      .d({sys_ff.tog_to, sys_ff.tog_addr}),
      .q({to_s, addr_s})
   );

   sah_sync #(.W(PROG_W + 1), .FILTER(1'b1)) u_pins_sys (
      .clk(clk_sys),
      .rst(1'b0),
      .d({scl_i, addr_pins}),
      .q({scl_s, pins_f})
   );

   sah_sync #(.W(4), .FILTER(1'b1)) u_to_sys (
      .clk(clk_sys),
      .rst(rst),
      .d({link_ff.cbus, link_ff.tog_rx, link_ff.tog_load, link_ff.tog_rst}),
      .q(tog_s)
   );

   // ------------------------------------------------------------
   // Link side protocol
   // ------------------------------------------------------------
   logic ev_rise;
   logic ev_fall;
   logic ev_fall8;
   logic ev_start;
   logic ev_stop;
   logic ev_to;
   logic quiet;
   logic [6:0] own_addr;

   assign ev_rise = scl_f & ~link_ff.scl_q;
   assign ev_fall = ~scl_f & link_ff.scl_q;
   assign ev_fall8 = ev_fall && (link_ff.cnt == `SAH_BITS_PER_BYTE);
   assign ev_start = scl_f & link_ff.scl_q & link_ff.sda_q & ~sda_f;
   assign ev_stop = scl_f & link_ff.scl_q & ~link_ff.sda_q & sda_f;
   assign ev_to = to_s != link_ff.to_q;
   assign quiet = !ev_start && !ev_stop && !third_line_data_enable_f && !ev_to;
   assign own_addr = (OWN_ADDR & ~PMASK) | (link_ff.own & PMASK);

   always_comb
   begin
      nxt_link = link_ff;
      nxt_link.scl_q = scl_f;
      nxt_link.sda_q = sda_f;
      nxt_link.sda_lvl = 1'b0;
      nxt_link.to_q = to_s;
      nxt_link.addr_q = addr_s;
      // The address word is stable on the system side before its toggle arrives.
      if (addr_s != link_ff.addr_q)
      begin
         nxt_link.own = sys_ff.prog_addr;
      end
      unique case (link_ff.st)
         sah_pkg::ST_IDLE, sah_pkg::ST_IGNORE:
         begin
         end
         sah_pkg::ST_ADDR, sah_pkg::ST_GC_CMD, sah_pkg::ST_DATA:
         begin
            if (ev_rise)
            begin
               nxt_link.sh = {link_ff.sh[6:0], sda_f};
               nxt_link.cnt = link_ff.cnt + 4'h1;
            end
            else if (ev_fall8)
            begin
               nxt_link.cnt = 4'h0;
               nxt_link.st = sah_pkg::ST_ACK;
               nxt_link.after = sah_pkg::ST_DATA;
               nxt_link.oe = 1'b1;
               if (link_ff.st == sah_pkg::ST_ADDR)
               begin
                  if (link_ff.sh == `SAH_START_BYTE)
                  begin
                     nxt_link.st = sah_pkg::ST_IGNORE;
                     nxt_link.oe = 1'b0;
                  end
                  else if (link_ff.sh[7:1] == `SAH_CBUS_ADDR)
                  begin
                     nxt_link.st = sah_pkg::ST_IGNORE;
                     nxt_link.oe = 1'b0;
                     nxt_link.cbus = 1'b1;
                  end
                  else if (link_ff.sh[7:1] == `SAH_GC_ADDR && !link_ff.sh[0])
                  begin
                     nxt_link.gc = 1'b1;
                     nxt_link.after = sah_pkg::ST_GC_CMD;
                     nxt_link.oe = gc_en_l;
                     if (!gc_en_l)
                     begin
                        nxt_link.st = sah_pkg::ST_IGNORE;
                     end
                  end
                  else if (link_ff.sh[7:1] == own_addr && !link_ff.sh[0])
                  begin
                     nxt_link.gc = 1'b0;
                  end
                  else
                  begin
                     nxt_link.st = sah_pkg::ST_IGNORE;
                     nxt_link.oe = 1'b0;
                  end
               end
               else if (link_ff.st == sah_pkg::ST_GC_CMD)
               begin
                  // Codes with the LSB set, 00h and undefined codes fall through untouched.
                  if (!link_ff.sh[0])
                  begin
                     if (link_ff.sh == `SAH_GC_RESET_LOAD)
                     begin
                        nxt_link.tog_rst = ~link_ff.tog_rst;
                     end
                     else if (link_ff.sh == `SAH_GC_LOAD_ONLY)
                     begin
                        nxt_link.tog_load = ~link_ff.tog_load;
                     end
                  end
               end
               else if (!link_ff.gc)
               begin
                  nxt_link.rx_byte = link_ff.sh;
                  nxt_link.tog_rx = ~link_ff.tog_rx;
               end
            end
         end
         sah_pkg::ST_ACK:
         begin
            if (ev_rise)
            begin
               nxt_link.cnt = 4'h1;
            end
            else if (ev_fall && link_ff.cnt == 4'h1)
            begin
               nxt_link.oe = 1'b0;
               nxt_link.cnt = 4'h0;
               nxt_link.st = link_ff.after;
            end
         end
      endcase
      if (ev_stop)
      begin
         nxt_link.st = sah_pkg::ST_IDLE;
         nxt_link.oe = 1'b0;
         nxt_link.cbus = 1'b0;
      end
      if (ev_start)
      begin
         nxt_link.st = sah_pkg::ST_ADDR;
         nxt_link.cnt = 4'h0;
         nxt_link.sh = 8'h00;
         nxt_link.oe = 1'b0;
         nxt_link.cbus = 1'b0;
      end
      // An active third line marks CBUS framing; stay off the bus until STOP or a new START.
      if (third_line_data_enable_f)
      begin
         nxt_link.st = sah_pkg::ST_IGNORE;
         nxt_link.oe = 1'b0;
         nxt_link.cbus = 1'b1;
      end
      if (ev_to)
      begin
         nxt_link.st = sah_pkg::ST_IDLE;
         nxt_link.oe = 1'b0;
         nxt_link.cnt = 4'h0;
      end
   end

   always_ff @(posedge clk_link)
   begin
      if (rst_link)
      begin
         link_ff <= LINK_RST;
      end
      else
      begin
         link_ff <= nxt_link;
      end
   end

   // ------------------------------------------------------------
   // System side: address load, reset pulse, timeout
   // ------------------------------------------------------------
   logic ev_rst;
   logic ev_load;
   logic ev_rx;

   assign pins_w = 7'(pins_f);
   assign ev_rst = tog_s[0] != sys_ff.tog_rst_q;
   assign ev_load = tog_s[1] != sys_ff.tog_load_q;
   assign ev_rx = tog_s[2] != sys_ff.tog_rx_q;

   always_comb
   begin
      nxt_sys = sys_ff;
      nxt_sys.tog_rst_q = tog_s[0];
      nxt_sys.tog_load_q = tog_s[1];
      nxt_sys.tog_rx_q = tog_s[2];
      nxt_sys.cbus = tog_s[3];
      nxt_sys.soft_reset = ev_rst;
      nxt_sys.rx_valid = 1'b0;
      nxt_sys.timeout = 1'b0;
      nxt_sys.boot = 1'b0;
      // Straps are also taken once right after reset release.
      if (sys_ff.boot || ev_rst || ev_load)
      begin
         nxt_sys.prog_addr = pins_w;
         nxt_sys.tog_addr = ~sys_ff.tog_addr;
      end
      if (ev_rx)
      begin
         nxt_sys.rx_data = link_ff.rx_byte;
         nxt_sys.rx_valid = 1'b1;
      end
      // The block never stretches the clock, so any long low is the controller.
      if (smbus_mode && !scl_s)
      begin
         if (sys_ff.to_cnt != TO_CAP)
         begin
            nxt_sys.to_cnt = sys_ff.to_cnt + `SAH_TO_CNT_W'(1);
         end
         if (sys_ff.to_cnt == TO_LAST)
         begin
            nxt_sys.timeout = 1'b1;
            nxt_sys.tog_to = ~sys_ff.tog_to;
         end
      end
      else
      begin
         nxt_sys.to_cnt = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sys_ff <= SYS_RST;
      end
      else
      begin
         sys_ff <= nxt_sys;
      end
   end

   assign sda_o = link_ff.sda_lvl;
   assign sda_oe = link_ff.oe;
   assign prog_addr = sys_ff.prog_addr[PROG_W-1:0];
   assign soft_reset = sys_ff.soft_reset;
   assign rx_data = sys_ff.rx_data;
   assign rx_valid = sys_ff.rx_valid;
   assign timeout = sys_ff.timeout;
   assign cbus_busy = sys_ff.cbus;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_start_resets;
      @(posedge clk_link) disable iff (rst_link)
      (ev_start && !third_line_data_enable_f && !ev_to) |=> (link_ff.st == sah_pkg::ST_ADDR) && !link_ff.oe;
   endproperty
   a_start_resets: assert property (p_start_resets)
      else $error("START did not return to address phase");

   property p_start_byte_nack;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_ADDR && ev_fall8 && link_ff.sh == `SAH_START_BYTE && quiet)
         |=> ((link_ff.st == sah_pkg::ST_IGNORE) && !link_ff.oe) [*2];
   endproperty
   a_start_byte_nack: assert property (p_start_byte_nack)
      else $error("START byte was acknowledged");

   property p_cbus_silent;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_ADDR && ev_fall8 && link_ff.sh[7:1] == `SAH_CBUS_ADDR && quiet)
         |=> link_ff.cbus && !link_ff.oe && (link_ff.st == sah_pkg::ST_IGNORE);
   endproperty
   a_cbus_silent: assert property (p_cbus_silent)
      else $error("CBUS address was answered");

   property p_gc_ack;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_ADDR && ev_fall8 && link_ff.sh == 8'h00 && quiet)
         |=> (link_ff.oe == $past(gc_en_l)) && link_ff.gc;
   endproperty
   a_gc_ack: assert property (p_gc_ack)
      else $error("General call acknowledge does not follow enable");

   property p_gc_reset_cmd;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_GC_CMD && ev_fall8 && link_ff.sh == `SAH_GC_RESET_LOAD)
         |=> (link_ff.tog_rst != $past(link_ff.tog_rst)) && $stable(link_ff.tog_load);
   endproperty
   a_gc_reset_cmd: assert property (p_gc_reset_cmd)
      else $error("Reset command not forwarded");

   property p_gc_ignored;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_GC_CMD && ev_fall8 && link_ff.sh != `SAH_GC_RESET_LOAD
         && link_ff.sh != `SAH_GC_LOAD_ONLY)
         |=> $stable(link_ff.tog_rst) && $stable(link_ff.tog_load) && $stable(link_ff.tog_rx);
   endproperty
   a_gc_ignored: assert property (p_gc_ignored)
      else $error("Undefined general call code acted upon");

   property p_gc_data_drop;
      @(posedge clk_link) disable iff (rst_link)
      (link_ff.st == sah_pkg::ST_DATA && link_ff.gc && ev_fall8 && quiet)
         |=> $stable(link_ff.tog_rx) && link_ff.oe;
   endproperty
   a_gc_data_drop: assert property (p_gc_data_drop)
      else $error("General call data byte was passed on");

   property p_stop_ready;
      @(posedge clk_link) disable iff (rst_link)
      (ev_stop && !third_line_data_enable_f && !ev_to) |=> (link_ff.st == sah_pkg::ST_IDLE) && !link_ff.cbus;
   endproperty
   a_stop_ready: assert property (p_stop_ready)
      else $error("STOP did not restore readiness");

   property p_to_clears;
      @(posedge clk_link) disable iff (rst_link)
      ev_to |=> (link_ff.st == sah_pkg::ST_IDLE) && !link_ff.oe;
   endproperty
   a_to_clears: assert property (p_to_clears)
      else $error("Timeout did not clear the bus interface");

   property p_timeout_pulse;
      @(posedge clk_sys) disable iff (rst)
      (smbus_mode && !scl_s && sys_ff.to_cnt == TO_LAST) |=> timeout ##1 !timeout;
   endproperty
   a_timeout_pulse: assert property (p_timeout_pulse)
      else $error("Clock low timeout missing or repeated");

   property p_reset_load;
      @(posedge clk_sys) disable iff (rst)
      ev_rst |=> soft_reset && (sys_ff.prog_addr == $past(pins_w));
   endproperty
   a_reset_load: assert property (p_reset_load)
      else $error("Software reset did not reset and load");

   property p_load_only;
      @(posedge clk_sys) disable iff (rst)
      (ev_load && !ev_rst) |=> !soft_reset && (sys_ff.prog_addr == $past(pins_w));
   endproperty
   a_load_only: assert property (p_load_only)
      else $error("Address load misbehaved");

   c_soft_reset: cover property (@(posedge clk_sys) disable iff (rst) soft_reset);
   c_start_byte: cover property (@(posedge clk_link) disable iff (rst_link)
      link_ff.st == sah_pkg::ST_ADDR && ev_fall8 && link_ff.sh == `SAH_START_BYTE);
   c_cbus: cover property (@(posedge clk_link) disable iff (rst_link) $rose(link_ff.cbus));
   c_timeout: cover property (@(posedge clk_sys) disable iff (rst) timeout);

endmodule

`default_nettype wire

// ---- src/sah_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module sah_sync #(
   parameter int W = 1,
   parameter bit FILTER = 1'b0
) (
   input wire logic clk, // Destination clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [W-1:0] d, // Asynchronous input
   output logic [W-1:0] q // Synchronised output
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } sah_sync_s;

   sah_sync_s state_ff;
   sah_sync_s nxt_state;

   if (W < 1)
   begin : g_chk
      $error("sah_sync width must be at least one");
   end

   // With the filter a bit only moves once the second and third stage agree,
   // which costs one cycle of latency but rejects single-sample glitches.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.s1 = d;
      nxt_state.s2 = state_ff.s1;
      nxt_state.s3 = state_ff.s2;
      for (int i = 0; i < W; i++)
      begin
         if (!FILTER)
         begin
            nxt_state.o[i] = state_ff.s2[i];
         end
         else if (state_ff.s2[i] == state_ff.s3[i])
         begin
            nxt_state.o[i] = state_ff.s3[i];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign q = state_ff.o;

endmodule

`default_nettype wire

// ---- verification/sah_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bus controller model
// ------------------------------------------------------------
// Bit timing is scaled down with the bench timeout, so every clock low half
// stays far shorter than the timeout, as the lowest allowed clock rate must.
module sah_ctrl_model #(
   parameter int HALF = 60
) (
   input wire logic clk, // Pacing clock
   input wire logic sda_in, // Resolved data line
   output logic scl, // Bus clock, idles high
   output logic sda // Data drive, high releases the line
);
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic hw(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves a quarter bit after the clock falls, clear of the pin filters.
   task automatic start();
      hw(HALF / 2);
      sda <= 1'b1;
      hw(HALF / 2);
      scl <= 1'b1;
      hw(HALF);
      sda <= 1'b0;
      hw(HALF);
      scl <= 1'b0;
   endtask

   task automatic stop();
      hw(HALF / 2);
      sda <= 1'b0;
      hw(HALF / 2);
      scl <= 1'b1;
      hw(HALF);
      sda <= 1'b1;
      hw(HALF);
   endtask

   task automatic xfer(input logic [7:0] b, output logic ack);
      logic [8:0] s;
      s = {b, 1'b1};
      for (int i = 0; i < 9; i++)
      begin
         hw(HALF / 2);
         sda <= s[8];
         s = s << 1;
         hw(HALF / 2);
         scl <= 1'b1;
         hw(HALF);
         ack = ~sda_in;
         scl <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sah_regs.svh"

module testbench;
   logic clk_sys, clk_link, rst, scl, sda, sda_o, sda_oe, tl, gce, smb, cbus_busy;
   logic srst, rxv, to, ack;
   logic [2:0] pins, prog;
   logic [7:0] rx;
   wire bus_sda;
   int n_errors = 0, n_compared = 0, n_srst = 0, n_rx = 0, n_to = 0;
   localparam logic [7:0] OWN_W = {7'h53, 1'b0};

   // ------------------------------------------------------------
   // Clocks, bus wiring and pulse counters
   // ------------------------------------------------------------
   assign bus_sda = (sda_oe && sda_o == 1'b0) ? 1'b0 : sda;
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial
   begin
      clk_link = 1'b0;
      #7;
      forever #24 clk_link = ~clk_link;
   end
   always @(posedge clk_sys)
   begin
      if (srst === 1'b1) n_srst++;
      if (rxv === 1'b1) n_rx++;
      if (to === 1'b1) n_to++;
   end

   sah_special_addr #(.TIMEOUT_CYC(200)) dut_u (.clk_sys(clk_sys), .rst(rst),
      .clk_link(clk_link), .scl_i(scl), .sda_i(bus_sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .third_line_data_enable(tl), .gc_enable(gce), .smbus_mode(smb), .addr_pins(pins),
      .prog_addr(prog), .soft_reset(srst), .rx_data(rx), .rx_valid(rxv), .timeout(to),
      .cbus_busy(cbus_busy));
   sah_ctrl_model ctl_u (.clk(clk_sys), .sda_in(bus_sda), .scl(scl), .sda(sda));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp);
      ctl_u.xfer(b, ack);
      chk("ack", {7'h0, exp}, {7'h0, ack});
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_gc(input logic [7:0] code, input logic [2:0] exp_p, input int rs);
      int s0;
      int r0;
      s0 = n_srst;
      r0 = n_rx;
      pins <= 3'h5 ^ code[2:0];
      ctl_u.start();
      send(8'h00, 1'b1);
      send(code, 1'b1);
      send(8'h5A, 1'b1);
      ctl_u.stop();
      idle(20);
      chk("prog_addr", {5'h0, exp_p}, {5'h0, prog});
      chk("soft_reset count", 8'(s0 + rs), 8'(n_srst));
      chk("rx count", 8'(r0), 8'(n_rx));
      $display("test general call %h done", code);
   endtask

   task automatic t_misc();
      int r0;
      r0 = n_rx;
      gce <= 1'b0;
      ctl_u.start();
      send(8'h00, 1'b0);
      ctl_u.start();
      send(`SAH_START_BYTE, 1'b0);
      gce <= 1'b1;
      ctl_u.start();
      send(OWN_W, 1'b1);
      send(8'hA5, 1'b1);
      ctl_u.stop();
      idle(20);
      chk("rx_data", 8'hA5, rx);
      chk("rx count", 8'(r0 + 1), 8'(n_rx));
      for (int a = 2; a < 4; a++)
      begin
         ctl_u.start();
         send(8'(a), 1'b0);
         tl <= 1'b1;
         send(OWN_W, 1'b0);
         chk("cbus_busy", 8'h01, {7'h0, cbus_busy});
         tl <= 1'b0;
         ctl_u.stop();
         idle(20);
         chk("cbus_busy", 8'h00, {7'h0, cbus_busy});
      end
      chk("rx count", 8'(r0 + 1), 8'(n_rx));
      $display("test start byte and cbus done");
   endtask

   // Smbus mode is left on only here so normal clock-low halves never count.
   task automatic t_timeout();
      int t0;
      t0 = n_to;
      for (int m = 0; m < 2; m++)
      begin
         smb <= m[0];
         ctl_u.start();
         idle(300);
         chk("timeout count", 8'(t0 + m), 8'(n_to));
         ctl_u.stop();
      end
      smb <= 1'b0;
      ctl_u.start();
      send(OWN_W, 1'b1);
      send(8'h3C, 1'b1);
      ctl_u.stop();
      idle(20);
      chk("rx_data", 8'h3C, rx);
      $display("test timeout done");
   endtask

   // A reset in mid-run retakes the straps and gives no reset pulse.
   task automatic t_reset();
      int s0;
      s0 = n_srst;
      pins <= 3'h6;
      idle(10);
      rst <= 1'b1;
      idle(12);
      rst <= 1'b0;
      idle(30);
      chk("prog_addr", 8'h06, {5'h0, prog});
      chk("soft_reset count", 8'(s0), 8'(n_srst));
      chk("rx_data", 8'h00, rx);
      $display("test mid-run reset done");
   endtask

   initial
   begin
      rst = 1'b1;
      tl = 1'b0;
      gce = 1'b1;
      smb = 1'b0;
      pins = 3'h2;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      idle(30);
      chk("prog_addr", 8'h02, {5'h0, prog});
      t_gc(`SAH_GC_LOAD_ONLY, 3'h1, 0);
      t_gc(`SAH_GC_RESET_LOAD, 3'h3, 1);
      t_gc(8'h07, 3'h3, 0);
      t_gc(8'h02, 3'h3, 0);
      t_misc();
      t_timeout();
      t_reset();
      close_out();
   end

   initial
   begin
      idle(80000);
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire
